// >>> logic/dma_pkg.sv
// Purpose: Shared constants for the transmit descriptor DMA engine
// Assumes: 32-bit descriptors words, byte-addressed system memory
// Notes: Register offsets are byte addresses on the Wishbone slave
package dma_pkg;
   // Descriptor geometry
   localparam int DESC_WORDS = 8;
   localparam int RX_WORDS = 4;
   localparam int RX_MAX = 64;
   localparam int RING_N = 4;
   localparam int LEN_W = 12;
   localparam int IRQ_N = 5;
   localparam int IRQ_STALL = 4;
   // Word 0 bit positions
   localparam int OWN_B = 31;
   localparam int DONE_B = 30;
   localparam int FIRST_B = 29;
   localparam int LAST_B = 28;
   localparam int RATE_LO = 24;
   localparam int RTS_ON_B = 23;
   localparam int RTSR_LO = 19;
   localparam int SELF_B = 18;
   localparam int FRAG_B = 17;
   localparam int SKIP_B = 15;
   // Word indices within a transmit descriptor
   localparam logic [2:0] W_CTRL = 3'h0;
   localparam logic [2:0] W_BUF = 3'h2;
   localparam logic [2:0] W_LEN = 3'h3;
   localparam logic [2:0] W_NEXT = 3'h4;
   localparam logic [2:0] W_LASTFETCH = 3'h7;
   localparam logic [2:0] W_LASTWB = 3'h1;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_POLL = 8'h04;
   localparam logic [7:0] REG_ISTAT = 8'h08;
   localparam logic [7:0] REG_IMASK = 8'h0c;
   localparam logic [7:0] REG_RTSLIM = 8'h10;
   localparam logic [7:0] REG_STATE = 8'h14;
   localparam logic [7:0] REG_RXBASE = 8'h30;
   localparam logic [3:0] REG_TXBASE_HI = 4'h2;
   localparam int CTRL_CIPHER_B = 4;
   localparam logic [11:0] RTSLIM_RST = 12'hfff;
   // Protection modes
   localparam logic [1:0] PROT_NONE = 2'h0;
   localparam logic [1:0] PROT_RTS = 2'h1;
   localparam logic [1:0] PROT_SELF = 2'h2;
   localparam logic [7:0] RATE_54 = 8'h6c;
endpackage

// >>> logic/speed_decode.sv
// Purpose: Map a 4-bit speed code to a rate in 500 kbit/s units
// Assumes: Reserved codes give zero and a clear valid flag
// Notes: Used for both frame and RTS speed codes
`timescale 1ns/1ns
module speed_decode (
   input wire logic [3:0] code_i,
   output logic [7:0] rate_o,
   output logic valid_o
);
   // Code table lookup, 1 to 54 Mbit/s
   function automatic logic [8:0] rate_of(input logic [3:0] c);
      unique case (c)
         4'h0: rate_of = 9'h102;
         4'h1: rate_of = 9'h104;
         4'h2: rate_of = 9'h10b;
         4'h3: rate_of = 9'h116;
         4'h4: rate_of = 9'h10c;
         4'h5: rate_of = 9'h112;
         4'h6: rate_of = 9'h118;
         4'h7: rate_of = 9'h124;
         4'h8: rate_of = 9'h130;
         4'h9: rate_of = 9'h148;
         4'ha: rate_of = 9'h160;
         4'hb: rate_of = 9'h16c;
         default: rate_of = 9'h000;
      endcase
   endfunction

   // Split valid flag from rate
   wire [8:0] lut = rate_of(code_i);
   assign rate_o = lut[7:0];
   assign valid_o = lut[8];
endmodule

// >>> logic/irq_status.sv
// Purpose: Sticky event bits, mask and one level interrupt
// Assumes: Clear is write-one-to-clear, one cycle pulse
// Notes: A set in the clear cycle wins
`timescale 1ns/1ns
module irq_status #(
   parameter int N = dma_pkg::IRQ_N
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [N-1:0] set_i,
   input wire logic [N-1:0] clr_i,
   input wire logic mask_we_i,
   input wire logic [N-1:0] mask_i,
   output logic [N-1:0] status_o,
   output logic [N-1:0] mask_o,
   output logic irq_o
);
   logic [N-1:0] status_r;
   logic [N-1:0] mask_r;

   // Sticky status and mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= '0;
         mask_r <= '0;
      end else begin
         status_r <= (status_r & ~clr_i) | set_i;
         if (mask_we_i) begin
            mask_r <= mask_i;
         end
      end
   end

   assign status_o = status_r;
   assign mask_o = mask_r;
   assign irq_o = |(status_r & mask_r);

   chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      (set_i != '0) |=> ((status_r & $past(set_i)) == $past(set_i)))
      else $error("event lost against clear");
endmodule

// >>> logic/wlan_tx_descriptor_dma.sv
// Purpose: Transmit descriptor ring DMA engine for a wireless LAN MAC
// Assumes: Wishbone classic slave registers, simple memory master port
// Notes: Beacon ring has the highest priority, low ring the lowest
// Operation
// - Four transmit rings, beacon/high/normal/low, and one receive array.
// - Transmit descriptor is eight words; receive array up to 64 four-word entries.
// - Bit 31 gives descriptor to device; device clears it when done.
// - Bit 30 requests an interrupt after last segment; interrupt only when masked in.
// - Frame speed code in bits 27:24 maps to 1..54 Mbit/s.
// - Bit 23 requests RTS/CTS for long unicast data or management frames.
// - RTS speed code in bits 22:19, ignored without RTS.
// - Bit 18 selects CTS-to-self instead of RTS/CTS.
// - Bit 17 marks more fragments to follow in the frame.
// - Bit 15 sends the frame unencrypted despite global cipher.
// - First and last segment bits frame one packet across descriptors.
// - Word 4 holds the pointer to the next descriptor.
// - Descriptor rewritten as status after transmit.
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module wlan_tx_descriptor_dma #(
   parameter int RX_DEPTH = dma_pkg::RX_MAX
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic mem_cyc_o,
   output logic mem_we_o,
   output logic [31:0] mem_adr_o,
   output logic [31:0] mem_dat_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_dat_i,
   output logic seg_valid_o,
   input wire logic seg_ready_i,
   output logic [31:0] seg_addr_o,
   output logic [11:0] seg_len_o,
   output logic seg_first_o,
   output logic seg_last_o,
   output logic [7:0] seg_rate_o,
   output logic [7:0] seg_rts_rate_o,
   output logic [1:0] seg_protect_o,
   output logic seg_frag_o,
   output logic seg_cipher_o,
   input wire logic seg_done_i,
   input wire logic hdr_data_mgmt_i,
   input wire logic hdr_unicast_i,
   input wire logic res_valid_i,
   input wire logic res_ok_i,
   input wire logic res_underrun_i,
   input wire logic [6:0] res_rts_retry_i,
   input wire logic [7:0] res_pkt_retry_i,
   input wire logic [15:0] res_exch_time_i,
   input wire logic rx_advance_i,
   output logic [31:0] rx_descr_addr_o,
   output logic irq_o
);
   localparam int RX_W = $clog2(RX_DEPTH);

   // Receive array depth must be a power of two up to the array limit
   if (RX_DEPTH < 2 || RX_DEPTH > dma_pkg::RX_MAX || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad
      $error("RX_DEPTH unsupported");
   end

   typedef enum {S_IDLE, S_FETCH, S_CHECK, S_SEG, S_RESULT, S_WB, S_NEXT} state_e;

   state_e st_r;
   logic [31:0] desc_r [dma_pkg::DESC_WORDS];
   logic [31:0] cur_r [dma_pkg::RING_N];
   logic [2:0] widx_r;
   logic [1:0] ring_r;
   logic [31:0] addr_r;
   logic [3:0] ring_en_r;
   logic [3:0] wait_r;
   logic cipher_en_r;
   logic [11:0] rts_lim_r;
   logic [31:0] rx_base_r;
   logic [RX_W-1:0] rx_idx_r;
   logic ack_r;
   logic [31:0] rd_r;
   logic seg_valid_r;
   logic [31:0] seg_addr_r;
   logic [11:0] seg_len_r;
   logic seg_first_r;
   logic seg_last_r;
   logic [7:0] seg_rate_r;
   logic [7:0] seg_rts_rate_r;
   logic [1:0] seg_prot_r;
   logic seg_frag_r;
   logic seg_cipher_r;
   logic [7:0] frame_rate;
   logic [7:0] rts_rate;
   logic [4:0] irq_stat;
   logic [4:0] irq_mask;

   // Lowest set index is the highest priority ring
   function automatic logic [1:0] pick(input logic [3:0] p);
      pick = 2'h3;
      for (int i = 3; i >= 0; i--) begin
         if (p[i]) begin
            pick = 2'(i);
         end
      end
   endfunction

   // Bus decode and byte lane mask
   wire wb_go = wb_cyc_i & wb_stb_i & ~ack_r;
   wire wr_go = wb_go & wb_we_i;
   wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wr_bits = wb_dat_i & bmask;
   wire hit_ctrl = wb_adr_i == dma_pkg::REG_CTRL;
   wire hit_poll = wb_adr_i == dma_pkg::REG_POLL;
   wire hit_istat = wb_adr_i == dma_pkg::REG_ISTAT;
   wire hit_imask = wb_adr_i == dma_pkg::REG_IMASK;
   wire hit_lim = wb_adr_i == dma_pkg::REG_RTSLIM;
   wire hit_state = wb_adr_i == dma_pkg::REG_STATE;
   wire hit_rx = wb_adr_i == dma_pkg::REG_RXBASE;
   wire hit_base = wb_adr_i[7:4] == dma_pkg::REG_TXBASE_HI;
   wire [1:0] base_idx = wb_adr_i[3:2];
   wire [31:0] ctrl_word = {27'h0, cipher_en_r, ring_en_r};
   wire [31:0] ctrl_new = (ctrl_word & ~bmask) | wr_bits;
   wire [31:0] lim_new = ({20'h0, rts_lim_r} & ~bmask) | wr_bits;
   wire [31:0] state_word = {16'h0, 8'(rx_idx_r), 5'h0, st_r != S_IDLE, ring_r};

   // Read data selection, unmapped offsets read zero
   wire [31:0] rd_val = hit_ctrl ? ctrl_word :
                        hit_poll ? {28'h0, wait_r} :
                        hit_istat ? {27'h0, irq_stat} :
                        hit_imask ? {27'h0, irq_mask} :
                        hit_lim ? {20'h0, rts_lim_r} :
                        hit_state ? state_word :
                        hit_rx ? rx_base_r :
                        hit_base ? cur_r[base_idx] : 32'h0;

   // One wait state slave, ack drops the cycle after it rose
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rd_r <= 32'h0;
      end else begin
         ack_r <= wb_go;
         if (wb_go && !wb_we_i) begin
            rd_r <= rd_val;
         end
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rd_r;

   // Descriptor decode of the fetched word 0
   wire [31:0] w0 = desc_r[dma_pkg::W_CTRL];
   wire [31:0] next_ptr = desc_r[dma_pkg::W_NEXT];
   wire [3:0] pend = ring_en_r & ~wait_r;
   wire long_frame = desc_r[dma_pkg::W_LEN][dma_pkg::LEN_W-1:0] > rts_lim_r;
   wire rts_need = w0[dma_pkg::RTS_ON_B] & hdr_data_mgmt_i & hdr_unicast_i & long_frame;
   wire [1:0] prot_nxt = w0[dma_pkg::SELF_B] ? dma_pkg::PROT_SELF :
                         rts_need ? dma_pkg::PROT_RTS : dma_pkg::PROT_NONE;
   wire seg_fin = st_r == S_SEG && !seg_valid_r && seg_done_i;
   wire owned = w0[dma_pkg::OWN_B];
   wire stall_evt = st_r == S_CHECK && !owned;
   wire done_evt = seg_fin && w0[dma_pkg::LAST_B] && w0[dma_pkg::DONE_B];
   wire [3:0] done_vec = {3'h0, done_evt} << ring_r;

   speed_decode u_frame_rate (
      .code_i(w0[dma_pkg::RATE_LO +: 4]),
      .rate_o(frame_rate),
      .valid_o()
   );

   speed_decode u_rts_rate (
      .code_i(w0[dma_pkg::RTSR_LO +: 4]),
      .rate_o(rts_rate),
      .valid_o()
   );

   irq_status #(.N(dma_pkg::IRQ_N)) u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i({stall_evt, done_vec}),
      .clr_i((wr_go && hit_istat) ? wr_bits[4:0] : 5'h0),
      .mask_we_i(wr_go && hit_imask),
      .mask_i(wr_bits[4:0]),
      .status_o(irq_stat),
      .mask_o(irq_mask),
      .irq_o(irq_o)
   );

   // Software controls; a stall from hardware wins over a poll clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ring_en_r <= 4'h0;
         cipher_en_r <= 1'b0;
         rts_lim_r <= dma_pkg::RTSLIM_RST;
         rx_base_r <= 32'h0;
         wait_r <= 4'h0;
      end else begin
         if (wr_go && hit_ctrl) begin
            ring_en_r <= ctrl_new[3:0];
            cipher_en_r <= ctrl_new[dma_pkg::CTRL_CIPHER_B];
         end
         if (wr_go && hit_lim) begin
            rts_lim_r <= lim_new[11:0];
         end
         if (wr_go && hit_rx) begin
            rx_base_r <= (rx_base_r & ~bmask) | wr_bits;
         end
         wait_r <= (wait_r & ~((wr_go && hit_poll) ? wr_bits[3:0] : 4'h0)) | ({3'h0, stall_evt} << ring_r);
      end
   end

   // Ring pointers: base writes load, completion follows the link
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < dma_pkg::RING_N; i++) begin
            cur_r[i] <= 32'h0;
         end
      end else if (wr_go && hit_base) begin
         cur_r[base_idx] <= (cur_r[base_idx] & ~bmask) | wr_bits;
      end else if (st_r == S_NEXT) begin
         cur_r[ring_r] <= next_ptr;
      end
   end

   // Receive array walk, wraps after the last entry
   always_ff @(posedge clk_i) begin
      if (rst_i || (wr_go && hit_rx)) begin
         rx_idx_r <= '0;
      end else if (rx_advance_i) begin
         rx_idx_r <= rx_idx_r + 1'b1;
      end
   end
   assign rx_descr_addr_o = rx_base_r + {20'h0, 8'(rx_idx_r), 4'h0};

   // Descriptor image: fetch, then status rewrite
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < dma_pkg::DESC_WORDS; i++) begin
            desc_r[i] <= 32'h0;
         end
      end else if (st_r == S_FETCH && mem_ack_i) begin
         desc_r[widx_r] <= mem_dat_i;
      end else if (seg_fin && !w0[dma_pkg::LAST_B]) begin
         desc_r[0] <= {2'b00, w0[dma_pkg::FIRST_B], w0[dma_pkg::LAST_B], 28'h0};
         desc_r[1] <= 32'h0;
      end else if (st_r == S_RESULT && res_valid_i) begin
         desc_r[0] <= {2'b00, w0[dma_pkg::FIRST_B], w0[dma_pkg::LAST_B], 11'h0,
                       res_underrun_i, res_ok_i, res_rts_retry_i, res_pkt_retry_i};
         desc_r[1] <= {res_exch_time_i, 16'h0};
      end
   end

   // Sequencer: pick ring, fetch, hand segment, write status, follow link
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= S_IDLE;
         widx_r <= 3'h0;
         ring_r <= 2'h0;
         addr_r <= 32'h0;
         seg_valid_r <= 1'b0;
      end else begin
         unique case (st_r)
            S_IDLE: if (|pend) begin
               ring_r <= pick(pend);
               addr_r <= cur_r[pick(pend)];
               widx_r <= 3'h0;
               st_r <= S_FETCH;
            end
            S_FETCH: if (mem_ack_i) begin
               widx_r <= widx_r + 3'h1;
               if (widx_r == dma_pkg::W_LASTFETCH) begin
                  st_r <= S_CHECK;
               end
            end
            S_CHECK: if (!owned) begin
               st_r <= S_IDLE;
            end else begin
               seg_valid_r <= 1'b1;
               st_r <= S_SEG;
            end
            S_SEG: begin
               if (seg_ready_i) begin
                  seg_valid_r <= 1'b0;
               end
               if (seg_fin) begin
                  st_r <= w0[dma_pkg::LAST_B] ? S_RESULT : S_WB;
               end
            end
            S_RESULT: if (res_valid_i) begin
               st_r <= S_WB;
            end
            S_WB: if (mem_ack_i) begin
               widx_r <= widx_r + 3'h1;
               if (widx_r == dma_pkg::W_LASTWB) begin
                  st_r <= S_NEXT;
               end
            end
            S_NEXT: st_r <= S_IDLE;
         endcase
      end
   end

   // Segment controls latched when an owned descriptor is accepted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seg_addr_r <= 32'h0;
         seg_len_r <= 12'h0;
         seg_first_r <= 1'b0;
         seg_last_r <= 1'b0;
         seg_rate_r <= 8'h0;
         seg_rts_rate_r <= 8'h0;
         seg_prot_r <= dma_pkg::PROT_NONE;
         seg_frag_r <= 1'b0;
         seg_cipher_r <= 1'b0;
      end else if (st_r == S_CHECK && owned) begin
         seg_addr_r <= desc_r[dma_pkg::W_BUF];
         seg_len_r <= desc_r[dma_pkg::W_LEN][dma_pkg::LEN_W-1:0];
         seg_first_r <= w0[dma_pkg::FIRST_B];
         seg_last_r <= w0[dma_pkg::LAST_B];
         seg_rate_r <= frame_rate;
         seg_rts_rate_r <= (prot_nxt == dma_pkg::PROT_RTS) ? rts_rate : 8'h0;
         seg_prot_r <= prot_nxt;
         seg_frag_r <= w0[dma_pkg::FRAG_B];
         seg_cipher_r <= cipher_en_r & ~w0[dma_pkg::SKIP_B];
      end
   end

   // Memory master: reads in fetch, writes back words 0 and 1
   assign mem_cyc_o = st_r == S_FETCH || st_r == S_WB;
   assign mem_we_o = st_r == S_WB;
   assign mem_adr_o = addr_r + {27'h0, widx_r, 2'b00};
   assign mem_dat_o = desc_r[widx_r];

   assign seg_valid_o = seg_valid_r;
   assign seg_addr_o = seg_addr_r;
   assign seg_len_o = seg_len_r;
   assign seg_first_o = seg_first_r;
   assign seg_last_o = seg_last_r;
   assign seg_rate_o = seg_rate_r;
   assign seg_rts_rate_o = seg_rts_rate_r;
   assign seg_protect_o = seg_prot_r;
   assign seg_frag_o = seg_frag_r;
   assign seg_cipher_o = seg_cipher_r;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_ring_priority: assert property ((st_r == S_IDLE && pend[0]) |=> (ring_r == 2'h0 && st_r == S_FETCH))
      else $error("beacon ring not served first");
   chk_fetch_eight: assert property ((st_r == S_FETCH && mem_ack_i && widx_r == 3'h7) |=> st_r == S_CHECK)
      else $error("fetch did not end at word seven");
   chk_wb_owner: assert property ((mem_we_o && widx_r == 3'h0) |-> mem_dat_o[31:30] == 2'b00)
      else $error("status word keeps owner or done bit");
   chk_rate_code: assert property (($rose(seg_valid_o) && w0[27:24] == 4'hb) |-> seg_rate_o == dma_pkg::RATE_54)
      else $error("frame speed code misdecoded");
   chk_rts_cond: assert property (($rose(seg_valid_o) && seg_protect_o == dma_pkg::PROT_RTS) |->
      (w0[dma_pkg::RTS_ON_B] && !w0[dma_pkg::SELF_B] && seg_len_o > rts_lim_r))
      else $error("RTS chosen without cause");
   chk_rts_rate_idle: assert property ((seg_valid_o && seg_protect_o != dma_pkg::PROT_RTS) |-> seg_rts_rate_o == 8'h0)
      else $error("RTS speed used without RTS");
   chk_self_prot: assert property (($rose(seg_valid_o) && w0[dma_pkg::SELF_B]) |-> seg_protect_o == dma_pkg::PROT_SELF)
      else $error("self protection not selected");
   chk_frag_mark: assert property ($rose(seg_valid_o) |-> seg_frag_o == w0[dma_pkg::FRAG_B])
      else $error("fragment mark lost");
   chk_cipher_skip: assert property ($rose(seg_valid_o) |-> seg_cipher_o == (cipher_en_r & ~w0[dma_pkg::SKIP_B]))
      else $error("cipher bypass wrong");
   chk_seg_marks: assert property ($rose(seg_valid_o) |-> (seg_first_o == w0[29] && seg_last_o == w0[28]))
      else $error("segment marks wrong");
   chk_next_follow: assert property (st_r == S_NEXT |=> cur_r[$past(ring_r)] == $past(next_ptr))
      else $error("next pointer not followed");
   chk_stall_hold: assert property (stall_evt |=> (wait_r[$past(ring_r)] && st_r == S_IDLE))
      else $error("engine passed a host-owned descriptor");

   cov_rts: cover property ($rose(seg_valid_o) && seg_protect_o == dma_pkg::PROT_RTS);
   cov_self: cover property ($rose(seg_valid_o) && seg_protect_o == dma_pkg::PROT_SELF);
   cov_stall: cover property (stall_evt);
   cov_multi_seg: cover property (seg_fin && !w0[dma_pkg::LAST_B] ##[1:300] done_evt);
endmodule

// >>> dv/host_mem_model.sv
// Purpose: System memory holding descriptor rings for the DMA engine
// Assumes: One word per access, ack pulse after delay_i idle cycles
// Notes: Read lines show inverted data outside an ack
`timescale 1ns/1ns
module host_mem_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] delay_i,
   input wire logic mem_cyc_i,
   input wire logic mem_we_i,
   input wire logic [31:0] mem_adr_i,
   input wire logic [31:0] mem_dat_i,
   output logic mem_ack_o,
   output logic [31:0] mem_dat_o
);
   logic [31:0] mem [0:127];
   logic [31:0] rdat_r;
   logic [1:0] wait_r;
   wire logic [6:0] idx = mem_adr_i[8:2];
   // Data is only meaningful while ack is up
   assign mem_dat_o = mem_ack_o ? rdat_r : ~rdat_r;
   // Ack after the chosen delay, store writebacks on the ack edge
   always @(posedge clk_i) begin
      if (rst_i || !mem_cyc_i || mem_ack_o) begin
         mem_ack_o <= 1'b0;
         wait_r <= 2'h0;
      end else if (wait_r == delay_i) begin
         mem_ack_o <= 1'b1;
         rdat_r <= mem[idx];
      end else begin
         wait_r <= wait_r + 2'h1;
      end
      if (mem_ack_o && mem_cyc_i && mem_we_i) begin
         mem[idx] <= mem_dat_i;
      end
   end
endmodule

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the transmit descriptor engine
// Assumes: High ring at 0x100, loop descriptor at 0x120 pointing at itself
// Notes: Segment side is served by the bench, memory by the model
`timescale 1ns/1ns
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, rd_q, wd;
   logic seg_ready_i = 1'b0, seg_done_i = 1'b0, res_valid_i = 1'b0, rx_advance_i = 1'b0;
   logic res_ok_i = 1'b1, res_underrun_i = 1'b0, unicast = 1'b1;
   logic [7:0] res_pkt_retry_i = 8'h21;
   logic [1:0] delay = 2'h0, prot;
   wire logic [31:0] wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i, seg_addr_o, rx_descr_addr_o;
   wire logic [11:0] seg_len_o;
   wire logic [7:0] seg_rate_o, seg_rts_rate_o;
   wire logic [1:0] seg_protect_o;
   wire logic wb_ack_o, mem_cyc_o, mem_we_o, mem_ack_i, seg_valid_o, seg_first_o, seg_last_o;
   wire logic seg_frag_o, seg_cipher_o, irq_o;
   int bad_count = 0, compares = 0;
   localparam logic [7:0] RATES [16] = '{8'h02, 8'h04, 8'h0b, 8'h16, 8'h0c, 8'h12, 8'h18, 8'h24,
      8'h30, 8'h48, 8'h60, 8'h6c, 8'h00, 8'h00, 8'h00, 8'h00};
   wlan_tx_descriptor_dma #(.RX_DEPTH(4)) i_wlan_tx_descriptor_dma (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .mem_cyc_o(mem_cyc_o), .mem_we_o(mem_we_o), .mem_adr_o(mem_adr_o), .mem_dat_o(mem_dat_o),
      .mem_ack_i(mem_ack_i), .mem_dat_i(mem_dat_i), .seg_valid_o(seg_valid_o), .seg_ready_i(seg_ready_i),
      .seg_addr_o(seg_addr_o), .seg_len_o(seg_len_o), .seg_first_o(seg_first_o), .seg_last_o(seg_last_o),
      .seg_rate_o(seg_rate_o), .seg_rts_rate_o(seg_rts_rate_o), .seg_protect_o(seg_protect_o),
      .seg_frag_o(seg_frag_o), .seg_cipher_o(seg_cipher_o), .seg_done_i(seg_done_i),
      .hdr_data_mgmt_i(1'b1), .hdr_unicast_i(unicast), .res_valid_i(res_valid_i), .res_ok_i(res_ok_i),
      .res_underrun_i(res_underrun_i), .res_rts_retry_i(7'h05), .res_pkt_retry_i(res_pkt_retry_i),
      .res_exch_time_i(16'h1234), .rx_advance_i(rx_advance_i), .rx_descr_addr_o(rx_descr_addr_o),
      .irq_o(irq_o));
   host_mem_model i_host_mem_model (.clk_i(clk_i), .rst_i(rst_i), .delay_i(delay), .mem_cyc_i(mem_cyc_o),
      .mem_we_i(mem_we_o), .mem_adr_i(mem_adr_o), .mem_dat_i(mem_dat_o), .mem_ack_o(mem_ack_i),
      .mem_dat_o(mem_dat_i));
   // Free-running 100 MHz clock
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Verdict and end of run
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_up(input string what);
      bad_count++;
      $display("[FAIL] %s expected response seen timeout", what);
      end_of_test();
   endtask
   // One classic Wishbone cycle, read data left in rd_q
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) give_up("wb_ack_o");
      rd_q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // Wait for a segment offer, leaving it unaccepted
   task automatic seg_wait();
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (seg_valid_o !== 1'b1 && n < 200);
      if (seg_valid_o !== 1'b1) give_up("seg_valid_o");
   endtask
   // Accept, report DMA done, then the frame result
   task automatic seg_finish();
      seg_ready_i <= 1'b1;
      @(posedge clk_i);
      seg_ready_i <= 1'b0;
      @(posedge clk_i);
      seg_done_i <= 1'b1;
      @(posedge clk_i);
      seg_done_i <= 1'b0;
      res_valid_i <= 1'b1;
      @(posedge clk_i);
      res_valid_i <= 1'b0;
   endtask
   // Poll until the high ring reports a host-owned stop
   task automatic wait_poll();
      int n;
      rd_q = 32'h0;
      for (n = 0; n < 40 && rd_q[1] !== 1'b1; n++) wb(1'b0, dma_pkg::REG_POLL, 32'h0);
      if (rd_q[1] !== 1'b1) give_up("stall flag");
   endtask
   // Main sequence
   initial begin
      int n;
      for (n = 0; n < 128; n++) i_host_mem_model.mem[n] = 32'h0;
      i_host_mem_model.mem[64] = 32'hfb9a_8000;
      i_host_mem_model.mem[66] = 32'h0000_2000;
      i_host_mem_model.mem[67] = 32'h0000_0100;
      i_host_mem_model.mem[68] = 32'h0000_0120;
      i_host_mem_model.mem[76] = 32'h0000_0120;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, dma_pkg::REG_RTSLIM, 32'h0);
      check("rts limit reset", 32'h0000_0fff, rd_q);
      wb(1'b0, 8'hfc, 32'h0);
      check("unmapped read", 32'h0, rd_q);
      wb(1'b1, dma_pkg::REG_RXBASE, 32'h0000_0400);
      for (n = 0; n < 5; n++) begin
         rx_advance_i <= 1'b1;
         @(posedge clk_i);
         rx_advance_i <= 1'b0;
         @(posedge clk_i);
      end
      check("rx entry", 32'h0000_0410, rx_descr_addr_o);
      wb(1'b1, 8'h24, 32'h0000_0100);
      wb(1'b1, dma_pkg::REG_IMASK, 32'h0000_0002);
      wb(1'b1, dma_pkg::REG_RTSLIM, 32'h0000_00ff);
      wb(1'b1, dma_pkg::REG_CTRL, 32'h0000_0013); // Beacon ring at 0 stalls first
      seg_wait();
      check("buffer", 32'h0000_2000, seg_addr_o);
      check("length", 32'h0000_0100, 32'(seg_len_o));
      check("marks", 32'h3, 32'({seg_first_o, seg_last_o}));
      check("rate", 32'h6c, 32'(seg_rate_o));
      check("rts rate", 32'h16, 32'(seg_rts_rate_o));
      check("protect", 32'(dma_pkg::PROT_RTS), 32'(seg_protect_o));
      check("fragments", 32'h1, 32'(seg_frag_o));
      check("cipher", 32'h0, 32'(seg_cipher_o));
      seg_finish();
      for (n = 0; n < 100 && irq_o !== 1'b1; n++) @(posedge clk_i);
      check("irq raised", 32'h1, 32'(irq_o));
      wait_poll();
      check("beacon stall", 32'h1, 32'(rd_q[0]));
      check("status word0", 32'h3000_8521, i_host_mem_model.mem[64]);
      check("status word1", 32'h1234_0000, i_host_mem_model.mem[65]);
      wb(1'b0, 8'h24, 32'h0);
      check("next pointer", 32'h0000_0120, rd_q);
      wb(1'b1, dma_pkg::REG_ISTAT, 32'h0000_0012);
      wb(1'b1, dma_pkg::REG_IMASK, 32'h0);
      check("irq cleared", 32'h0, 32'(irq_o));
      for (int i = 0; i < 16; i++) begin
         wd = 32'hb000_0000 | (32'(i) << 24) | (32'(i & 15) << 19);
         wd[23] = i[0];
         wd[18] = i[1] & ~i[2];
         wd[30] = (i == 15);
         wd[29] = (i != 15); // Pass 14 opens a packet, pass 15 closes it
         wd[28] = (i != 14);
         prot = wd[18] ? dma_pkg::PROT_SELF : (i[0] && !i[2] && i != 9) ? dma_pkg::PROT_RTS : dma_pkg::PROT_NONE;
         unicast <= (i != 9);
         i_host_mem_model.mem[72] = wd;
         i_host_mem_model.mem[75] = i[2] ? 32'h0000_00ff : 32'h0000_0100;
         res_underrun_i <= i[0];
         res_ok_i <= ~i[0];
         res_pkt_retry_i <= 8'(i);
         delay <= 2'(i);
         wb(1'b1, dma_pkg::REG_POLL, 32'h0000_0002);
         seg_wait();
         check("rate", 32'(RATES[i]), 32'(seg_rate_o));
         check("protect", 32'(prot), 32'(seg_protect_o));
         check("rts rate", prot == dma_pkg::PROT_RTS ? 32'(RATES[i]) : 32'h0, 32'(seg_rts_rate_o));
         check("cipher", 32'h1, 32'(seg_cipher_o));
         check("marks", {30'h0, wd[29:28]}, 32'({seg_first_o, seg_last_o}));
         seg_finish();
         wait_poll();
         wd = (i == 14) ? 32'h2000_0000 : {2'h0, wd[29:28], 11'h0, i[0], ~i[0], 7'h05, 8'(i)};
         check("status", wd, i_host_mem_model.mem[72]);
      end
      wb(1'b0, dma_pkg::REG_ISTAT, 32'h0);
      check("masked done", 32'h2, rd_q & 32'h2);
      check("irq masked", 32'h0, 32'(irq_o));
      end_of_test();
   end
endmodule
